/* File: factory_info_bank.sv */
// APB slave presenting the read-only factory information bank
//
// What this block does
// - Contents are factory values that no software write or erase can change.
// - Only application-side accesses reach the bank; radio-core accesses are refused.
// - Configuration identifier word at 0x200 returns the hardware ident number.
// - 64-bit unique identifier spans two words at 0x204 plus n times 4.
// - Word zero holds the identifier's low half, word one the high half.
// - Word 0x210 encodes part variant, hardware version and production configuration.
// - Word 0x220 reports the program memory page size in bytes.
// - Trim pairs from 0x300/0x304 give target register address and its data.
// - Four tag-header words 0x450 to 0x45C supply the tag identifier's last bytes.
// - Word 0xC00 gives bytes the random generator collects for entropy.
// - Startup test bytes at 0xC0C, repetition and proportion cutoffs at 0xC04/0xC08.
// - Four ring-oscillator sample counts sit at 0xC10 through 0xC1C.
// - Word 0xC20 holds the crystal oscillator load-capacitor trim values.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module factory_info_bank
  import factory_info_pkg::*;
#(
  parameter info_image_t INFO_IMAGE = INFO_BLANK,
  parameter trim_image_t TRIM_IMAGE = TRIM_BLANK
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [factory_info_pkg::ADDR_W-1:0] paddr,
  input wire logic [factory_info_pkg::DATA_W-1:0] pwdata,
  input wire logic radio_core_access,
  output logic [factory_info_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import factory_info_pkg::*;

  // ----------------------------------------------------------------
  // Address lookup
  // ----------------------------------------------------------------
  // The image lives in parameters, so there is no storage element that
  // a write could ever reach; programming happens at build time only.
  function automatic bank_resp_t lookup(input logic [ADDR_W-1:0] a);
    bank_resp_t r;
    r.hit = 1'b1;
    r.data = WORD_ZERO;
    if (a[ADDR_W-1:8] == TRIM_PAGE)
    begin
      r.data = TRIM_IMAGE[a[7:2]];
    end
    else
    begin
      case (a)
        OFS_CONFIG_IDENTIFIER: r.data = INFO_IMAGE[SLOT_CONFIG];
        OFS_UNIQUE_ID_WORD: r.data = INFO_IMAGE[SLOT_UID_LOW];
        OFS_UNIQUE_ID_WORD + OFS_UNIQUE_ID_STEP: r.data = INFO_IMAGE[SLOT_UID_HIGH];
        OFS_PART_CODE: r.data = INFO_IMAGE[SLOT_PART_CODE];
        OFS_PART_VARIANT: r.data = INFO_IMAGE[SLOT_VARIANT];
        OFS_PACKAGE_OPTION: r.data = INFO_IMAGE[SLOT_PACKAGE];
        OFS_RAM_VARIANT: r.data = INFO_IMAGE[SLOT_RAM];
        OFS_FLASH_VARIANT: r.data = INFO_IMAGE[SLOT_FLASH];
        OFS_CODE_PAGE_SIZE: r.data = INFO_IMAGE[SLOT_PAGE_SIZE];
        OFS_CODE_MEMORY_SIZE: r.data = INFO_IMAGE[SLOT_CODE_SIZE];
        OFS_DEVICE_TYPE: r.data = INFO_IMAGE[SLOT_DEVICE_TYPE];
        OFS_TAG_HEADER_WORD0: r.data = INFO_IMAGE[SLOT_TAG0];
        OFS_TAG_HEADER_WORD1: r.data = INFO_IMAGE[SLOT_TAG1];
        OFS_TAG_HEADER_WORD2: r.data = INFO_IMAGE[SLOT_TAG2];
        OFS_TAG_HEADER_WORD3: r.data = INFO_IMAGE[SLOT_TAG3];
        OFS_ENTROPY_BYTE_COUNT: r.data = INFO_IMAGE[SLOT_RNG_BYTES];
        OFS_REPETITION_CUTOFF: r.data = INFO_IMAGE[SLOT_RNG_RCUT];
        OFS_PROPORTION_CUTOFF: r.data = INFO_IMAGE[SLOT_RNG_APCUT];
        OFS_STARTUP_TEST_BYTES: r.data = INFO_IMAGE[SLOT_RNG_STARTUP];
        OFS_RING_OSC1_SAMPLES: r.data = INFO_IMAGE[SLOT_RING_OSC1];
        OFS_RING_OSC2_SAMPLES: r.data = INFO_IMAGE[SLOT_RING_OSC2];
        OFS_RING_OSC3_SAMPLES: r.data = INFO_IMAGE[SLOT_RING_OSC3];
        OFS_RING_OSC4_SAMPLES: r.data = INFO_IMAGE[SLOT_RING_OSC4];
        OFS_CRYSTAL_CAP_TRIM: r.data = INFO_IMAGE[SLOT_XTAL_TRIM];
        default: r.hit = 1'b0;
      endcase
    end
    return r;
  endfunction : lookup

  // ----------------------------------------------------------------
  // Setup-phase decode
  // ----------------------------------------------------------------
  logic setup_phase;
  bank_resp_t resp;
  logic blocked;
  logic [DATA_W-1:0] rdata_next;
  logic err_next;

  assign setup_phase = psel & ~penable;
  assign resp = lookup(paddr);
  assign blocked = radio_core_access;

  always_comb
  begin
    rdata_next = WORD_ZERO;
    err_next = 1'b0;
    if (blocked)
    begin
      err_next = 1'b1;
    end
    else if (!resp.hit)
    begin
      err_next = 1'b1;
    end
    else if (!pwrite)
    begin
      rdata_next = resp.data;
    end
    // Writes to mapped words fall through: no data, no error
  end

  // ----------------------------------------------------------------
  // Handshake state
  // ----------------------------------------------------------------
  apb_state_t state_reg;
  apb_state_t state_next;

  always_comb
  begin
    case (state_reg)
      ST_IDLE: state_next = setup_phase ? ST_ACCESS : ST_IDLE;
      ST_ACCESS: state_next = (psel & penable) ? ST_IDLE : ST_ACCESS;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------
  // Captured at the setup edge so the read data comes from flops and
  // the slave can answer in the first access cycle without a wait.
  logic [DATA_W-1:0] rdata_reg;
  logic err_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= WORD_ZERO;
    end
    else if (setup_phase)
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = psel & penable & (state_reg == ST_ACCESS);
  assign pslverr = pready & err_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_read_setup(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && !radio_core_access && (paddr == a);
  endsequence

  sequence s_write_setup(logic [ADDR_W-1:0] a);
    psel && !penable && pwrite && !radio_core_access && (paddr == a);
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  property p_read_word(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    @(posedge pclk) disable iff (!presetn)
      s_read_setup(a) ##1 s_access |-> (prdata == v) && pready && !pslverr;
  endproperty

  AST_CONFIG_WORD: assert property (p_read_word(OFS_CONFIG_IDENTIFIER,
      INFO_IMAGE[SLOT_CONFIG]))
    else $error("config identifier read mismatch");

  AST_UID_LOW: assert property (p_read_word(OFS_UNIQUE_ID_WORD,
      INFO_IMAGE[SLOT_UID_LOW]))
    else $error("unique id low word mismatch");

  AST_UID_HIGH: assert property (p_read_word(OFS_UNIQUE_ID_WORD + OFS_UNIQUE_ID_STEP,
      INFO_IMAGE[SLOT_UID_HIGH]))
    else $error("unique id high word mismatch");

  AST_VARIANT_WORD: assert property (p_read_word(OFS_PART_VARIANT,
      INFO_IMAGE[SLOT_VARIANT]))
    else $error("part variant read mismatch");

  AST_PAGE_SIZE: assert property (p_read_word(OFS_CODE_PAGE_SIZE,
      INFO_IMAGE[SLOT_PAGE_SIZE]))
    else $error("page size read mismatch");

  AST_TRIM_PAIR: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_read_setup(OFS_TRIM_VALUE) ##1 s_access |-> prdata == TRIM_IMAGE[1])
    else $error("first trim value mismatch");

  AST_TAG_HEADER: assert property (p_read_word(OFS_TAG_HEADER_WORD3,
      INFO_IMAGE[SLOT_TAG3]))
    else $error("tag header word mismatch");

  AST_ENTROPY_BYTES: assert property (p_read_word(OFS_ENTROPY_BYTE_COUNT,
      INFO_IMAGE[SLOT_RNG_BYTES]))
    else $error("entropy byte count mismatch");

  AST_STARTUP_BYTES: assert property (p_read_word(OFS_STARTUP_TEST_BYTES,
      INFO_IMAGE[SLOT_RNG_STARTUP]))
    else $error("startup test bytes mismatch");

  AST_RING_OSC4: assert property (p_read_word(OFS_RING_OSC4_SAMPLES,
      INFO_IMAGE[SLOT_RING_OSC4]))
    else $error("ring oscillator count mismatch");

  AST_XTAL_TRIM: assert property (p_read_word(OFS_CRYSTAL_CAP_TRIM,
      INFO_IMAGE[SLOT_XTAL_TRIM]))
    else $error("crystal trim read mismatch");

  AST_RADIO_REFUSED: assert property (
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && radio_core_access) ##1 s_access
        |-> pslverr && (prdata == WORD_ZERO))
    else $error("radio core access was not refused");

  AST_WRITE_NO_ERROR: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_write_setup(OFS_CONFIG_IDENTIFIER) ##1 s_access |-> pready && !pslverr)
    else $error("write to bank word raised an error");

  AST_WRITE_NO_EFFECT: assert property (
    @(posedge pclk) disable iff (!presetn)
      s_write_setup(OFS_UNIQUE_ID_WORD) ##1 s_access ##1 s_read_setup(OFS_UNIQUE_ID_WORD)
        ##1 s_access |-> prdata == INFO_IMAGE[SLOT_UID_LOW])
    else $error("write altered a factory word");

  AST_NO_WAIT: assert property (
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 s_access |-> pready)
    else $error("access phase not answered at once");

endmodule : factory_info_bank

`default_nettype wire

/* File: factory_info_pkg.sv */
// Constants, layouts and carrier types of the factory information bank
package factory_info_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Word offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONFIG_IDENTIFIER = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_UNIQUE_ID_WORD = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_UNIQUE_ID_STEP = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PART_CODE = 12'h20C;
  localparam logic [ADDR_W-1:0] OFS_PART_VARIANT = 12'h210;
  localparam logic [ADDR_W-1:0] OFS_PACKAGE_OPTION = 12'h214;
  localparam logic [ADDR_W-1:0] OFS_RAM_VARIANT = 12'h218;
  localparam logic [ADDR_W-1:0] OFS_FLASH_VARIANT = 12'h21C;
  localparam logic [ADDR_W-1:0] OFS_CODE_PAGE_SIZE = 12'h220;
  localparam logic [ADDR_W-1:0] OFS_CODE_MEMORY_SIZE = 12'h224;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_TYPE = 12'h228;
  localparam logic [ADDR_W-1:0] OFS_TRIM_TARGET_ADDRESS = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_TRIM_VALUE = 12'h304;
  localparam logic [ADDR_W-1:0] OFS_TAG_HEADER_WORD0 = 12'h450;
  localparam logic [ADDR_W-1:0] OFS_TAG_HEADER_WORD1 = 12'h454;
  localparam logic [ADDR_W-1:0] OFS_TAG_HEADER_WORD2 = 12'h458;
  localparam logic [ADDR_W-1:0] OFS_TAG_HEADER_WORD3 = 12'h45C;
  localparam logic [ADDR_W-1:0] OFS_ENTROPY_BYTE_COUNT = 12'hC00;
  localparam logic [ADDR_W-1:0] OFS_REPETITION_CUTOFF = 12'hC04;
  localparam logic [ADDR_W-1:0] OFS_PROPORTION_CUTOFF = 12'hC08;
  localparam logic [ADDR_W-1:0] OFS_STARTUP_TEST_BYTES = 12'hC0C;
  localparam logic [ADDR_W-1:0] OFS_RING_OSC1_SAMPLES = 12'hC10;
  localparam logic [ADDR_W-1:0] OFS_RING_OSC2_SAMPLES = 12'hC14;
  localparam logic [ADDR_W-1:0] OFS_RING_OSC3_SAMPLES = 12'hC18;
  localparam logic [ADDR_W-1:0] OFS_RING_OSC4_SAMPLES = 12'hC1C;
  localparam logic [ADDR_W-1:0] OFS_CRYSTAL_CAP_TRIM = 12'hC20;

  // ----------------------------------------------------------------
  // Trim pair region: even word is target address, odd word is value
  // ----------------------------------------------------------------
  localparam int TRIM_PAIRS = 32;
  localparam int TRIM_WORDS = 2 * TRIM_PAIRS;
  localparam logic [3:0] TRIM_PAGE = 4'h3;

  // ----------------------------------------------------------------
  // Slot numbers inside the fixed information image
  // ----------------------------------------------------------------
  localparam int SLOT_CONFIG = 0;
  localparam int SLOT_UID_LOW = 1;
  localparam int SLOT_UID_HIGH = 2;
  localparam int SLOT_PART_CODE = 3;
  localparam int SLOT_VARIANT = 4;
  localparam int SLOT_PACKAGE = 5;
  localparam int SLOT_RAM = 6;
  localparam int SLOT_FLASH = 7;
  localparam int SLOT_PAGE_SIZE = 8;
  localparam int SLOT_CODE_SIZE = 9;
  localparam int SLOT_DEVICE_TYPE = 10;
  localparam int SLOT_TAG0 = 11;
  localparam int SLOT_TAG1 = 12;
  localparam int SLOT_TAG2 = 13;
  localparam int SLOT_TAG3 = 14;
  localparam int SLOT_RNG_BYTES = 15;
  localparam int SLOT_RNG_RCUT = 16;
  localparam int SLOT_RNG_APCUT = 17;
  localparam int SLOT_RNG_STARTUP = 18;
  localparam int SLOT_RING_OSC1 = 19;
  localparam int SLOT_RING_OSC2 = 20;
  localparam int SLOT_RING_OSC3 = 21;
  localparam int SLOT_RING_OSC4 = 22;
  localparam int SLOT_XTAL_TRIM = 23;
  localparam int NUM_SLOTS = 24;

  // ----------------------------------------------------------------
  // Values and types
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_ERASED = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef logic [NUM_SLOTS-1:0][DATA_W-1:0] info_image_t;
  typedef logic [TRIM_WORDS-1:0][DATA_W-1:0] trim_image_t;

  localparam info_image_t INFO_BLANK = {NUM_SLOTS{WORD_ERASED}};
  localparam trim_image_t TRIM_BLANK = {TRIM_WORDS{WORD_ERASED}};

  // Result of one address lookup
  typedef struct packed {
    logic hit;
    logic [DATA_W-1:0] data;
  } bank_resp_t;

  // Bus handshake phases
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;

endpackage : factory_info_pkg

/* File: factory_info_register_bank_tb.sv */
// Self-checking testbench for the factory information bank
`timescale 1ns/10ps
`default_nettype none

module factory_info_register_bank_tb;
  import factory_info_pkg::*;

  // ----------------------------------------------------------------
  // Contents programmed into the bank under test
  // ----------------------------------------------------------------
  function automatic info_image_t mk_info();
    info_image_t r;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      r[i] = 32'h3C00_0000 + 32'(i) * 32'h0001_0203;
    end
    return r;
  endfunction : mk_info

  function automatic trim_image_t mk_trim();
    trim_image_t r;
    for (int i = 0; i < TRIM_WORDS; i++)
    begin
      r[i] = 32'hD000_0000 + 32'(i) * 32'h0100_0011;
    end
    return r;
  endfunction : mk_trim

  localparam info_image_t IMG = mk_info();
  localparam trim_image_t TIMG = mk_trim();

  logic pclk, presetn, psel, penable, pwrite, radio_core_access;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, prdata_b, rd, rb;
  logic pready, pslverr, pready_b, pslverr_b, er;
  int seed = 35545;
  int checks = 0;
  int miscompares = 0;
  logic [ADDR_W-1:0] corner [6] = '{12'h200, 12'h204, 12'h208, 12'h304, 12'h45C, 12'hC20};

  // Main instance holds distinct words; the second keeps the erased default
  factory_info_bank #(.INFO_IMAGE(IMG), .TRIM_IMAGE(TIMG)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .radio_core_access(radio_core_access), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  factory_info_bank blank_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .radio_core_access(radio_core_access), .prdata(prdata_b), .pready(pready_b),
    .pslverr(pslverr_b));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Address decode worked out from the offsets; aligned addresses only
  function automatic bank_resp_t expect_word(input logic [ADDR_W-1:0] a);
    bank_resp_t r;
    int s;
    s = -1;
    r.hit = 1'b0;
    r.data = WORD_ZERO;
    if (a == OFS_CONFIG_IDENTIFIER) s = SLOT_CONFIG;
    else if (a == OFS_UNIQUE_ID_WORD) s = SLOT_UID_LOW;
    else if (a == OFS_UNIQUE_ID_WORD + OFS_UNIQUE_ID_STEP) s = SLOT_UID_HIGH;
    else if (a >= OFS_PART_CODE && a <= OFS_DEVICE_TYPE) s = SLOT_PART_CODE + int'(a[7:2] - 3);
    else if (a >= OFS_TAG_HEADER_WORD0 && a <= OFS_TAG_HEADER_WORD3)
      s = SLOT_TAG0 + int'(a[3:2]);
    else if (a >= OFS_ENTROPY_BYTE_COUNT && a <= OFS_CRYSTAL_CAP_TRIM) s = SLOT_RNG_BYTES + int'(a[5:2]);
    if (a[11:8] == TRIM_PAGE)
    begin
      r.hit = 1'b1;
      r.data = TIMG[a[7:2]];
    end
    else if (s >= 0)
    begin
      r.hit = 1'b1;
      r.data = IMG[s];
    end
    return r;
  endfunction : expect_word

  // ----------------------------------------------------------------
  // APB master; keep leaves psel up so the next setup follows at once
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                     input logic rc, input bit keep);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    radio_core_access <= rc;
    @(negedge pclk);
    chk(32'(pready), 32'h0, "ready in setup");
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Read before this edge's own updates land, so these are the sampled values
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("ERROR t=%0t no ready", $time);
      conclude();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      rb = prdata_b;
      chk(32'(n), 32'h1, "wait states");
      if (!keep)
      begin
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never drives psel twice in one step
        @(posedge pclk);
      end
    end
  endtask : apb

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic rc, input bit keep);
    bank_resp_t e;
    e = expect_word(a);
    apb(1'b0, a, 32'($random(seed)), rc, keep);
    if (rc)
    begin
      chk(32'(er), 32'h1, "radio read error");
      chk(rd, WORD_ZERO, "radio read data");
    end
    else
    begin
      chk(rd, e.hit ? e.data : WORD_ZERO, "read data");
      chk(32'(er), 32'(!e.hit), "read error");
      chk(rb, e.hit ? WORD_ERASED : WORD_ZERO, "erased data");
    end
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [ADDR_W-1:0] a;
    logic rc;
    bank_resp_t e;
    presetn = 1'b0;
    {psel, penable, pwrite, radio_core_access} = 4'h0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4096; i += 4) rd_chk(12'(i), 1'b0, i < 4092);
    // Zero writes over erased-looking words must leave them intact
    foreach (corner[i])
    begin
      apb(1'b1, corner[i], WORD_ZERO, 1'b0, 1'b1);
      chk(32'(er), 32'h0, "mapped write error");
      rd_chk(corner[i], 1'b0, 1'b1);
      rd_chk(corner[i], 1'b1, 1'b1);
    end
    repeat (300)
    begin
      a = ($random(seed) & 1) ? (12'h300 | 12'($random(seed) & 12'h0FC)) : 12'($random(seed) & 12'hFFC);
      rc = ($random(seed) & 3) == 0;
      e = expect_word(a);
      apb(1'b1, a, 32'($random(seed)), rc, 1'b1);
      chk(32'(er), 32'(rc | !e.hit), "write error");
      rd_chk(a, 1'b0, 1'b1);
    end
    rd_chk(12'h200, 1'b0, 1'b0);
    // Reset in mid-run: contents come back unchanged
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'({pready, pslverr}), 32'h0, "outputs in reset");
    chk(prdata, WORD_ZERO, "read data in reset");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (corner[i]) rd_chk(corner[i], 1'b0, i < 5);
    conclude();
  end

endmodule : factory_info_register_bank_tb

`default_nettype wire
